// ---- hw/rst_seq_pkg.sv ----
package rst_seq_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int REJECT_US = 5;
	localparam int ACCEPT_US = 9;
	localparam int SLEEP_DONE_MS = 5;
	localparam int AWAKE_DONE_MS = 120;
	// Filter threshold sits between the reject and accept widths
	localparam int FILT_US = (REJECT_US + ACCEPT_US) / 2;
	localparam int FILT_CYC = FILT_US * CLK_MHZ;
	localparam int SLEEP_DONE_CYC = SLEEP_DONE_MS * 1000 * CLK_MHZ;
	localparam int AWAKE_DONE_CYC = AWAKE_DONE_MS * 1000 * CLK_MHZ;
	// ----------------------------------------
	// Settings store
	// ----------------------------------------
	localparam int NVM_WORDS = 8;
	localparam int NVM_AW = 3;
	localparam int NVM_DW = 8;
	localparam int CV_WORD_IDX = 3;
	localparam logic [7:0] CFG_DEFAULT = 8'h00;
endpackage : rst_seq_pkg

// ---- hw/nvm_if.sv ----
`timescale 1ns/1ps
interface nvm_if #(parameter int AW = 3, parameter int DW = 8);
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	modport ctrl (output rd_en, output rd_addr, input rd_data);
	modport mem (input rd_en, input rd_addr, output rd_data);
endinterface : nvm_if

// ---- hw/nvm_store.sv ----
`timescale 1ns/1ps
module nvm_store #(parameter int AW = 3, parameter int DW = 8) (
	input wire logic sys_clk_i,
	nvm_if.mem bus
);
	// Contents stand in for programmed non-volatile cells
	logic [DW-1:0] cells [0:(1<<AW)-1];
	logic [DW-1:0] rd_q;
	always_comb begin
		for (int i = 0; i < (1<<AW); i++) begin
			cells[i] = DW'(8'h11 * i + 8'h05);
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (bus.rd_en) begin
			rd_q <= cells[bus.rd_addr];
		end
	end
	assign bus.rd_data = rd_q;
endmodule : nvm_store

// ---- hw/display_hw_reset_sequencer.sv ----
`timescale 1ns/1ps
// Operation
// (RULE_01) Reset line active low, host drives it
// (RULE_02) Ignore lows under 5us, reset over 9us
// (RULE_03) Filter high spikes inside valid pulse
// (RULE_04) Reload stored settings after each release
// (RULE_05) Blank panel during reset sequence
// (RULE_06) Restore defaults when reset finishes
// (RULE_07) Done within 5ms asleep, 120ms awake
// (RULE_08) Host waits 5ms before commands
// (RULE_09) Host waits 120ms before wake
// (RULE_10) Busy flag gates commands until done
module display_hw_reset_sequencer #(
	parameter int FILT_CYC = rst_seq_pkg::FILT_CYC,
	parameter int SLEEP_CYC = rst_seq_pkg::SLEEP_DONE_CYC,
	parameter int AWAKE_CYC = rst_seq_pkg::AWAKE_DONE_CYC
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic reset_line_n_i,
	input wire logic awake_i,
	input wire logic cmd_valid_i,
	output logic busy_o,
	output logic blank_o,
	output logic cmd_accept_o,
	output logic defaults_load_o,
	output logic [7:0] common_voltage_setting_o,
	output logic [7:0] id_checksum_o
);
	// Reload takes two cycles a word, so the sleep window must cover filter plus reload
	if (FILT_CYC < 1 || SLEEP_CYC <= FILT_CYC + 2 * rst_seq_pkg::NVM_WORDS ||
			AWAKE_CYC < SLEEP_CYC) begin : g_bad_timing
		$error("bad timing parameters");
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------
	// Pin synchroniser and glitch filter
	// ----------------------------------------
	logic sync1, sync2, filt, next_filt;
	logic [31:0] fcnt, next_fcnt;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else begin
			sync1 <= reset_line_n_i; // see (RULE_01)
			sync2 <= sync1;
		end
	end
	// Level only changes after it holds for the filter time, both directions
	always_comb begin
		next_filt = filt;
		next_fcnt = 32'd0;
		if (sync2 != filt) begin
			next_fcnt = fcnt + 32'd1;
			if (fcnt == 32'(FILT_CYC - 1)) begin // see (RULE_02) see (RULE_03)
				next_filt = sync2;
				next_fcnt = 32'd0;
			end
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			filt <= 1'b1;
			fcnt <= 32'd0;
		end else begin
			filt <= next_filt;
			fcnt <= next_fcnt;
		end
	end
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {IDLE, HELD, LOAD, WAIT} state_t;
	state_t state, next_state;
	logic [31:0] tcnt, next_tcnt, limit, next_limit;
	logic [2:0] addr, next_addr;
	logic rd_pend, next_rd_pend;
	logic busy, next_busy, blank, next_blank, acc, next_acc, dflt, next_dflt;
	logic [7:0] cv_set, next_cv_set, csum, next_csum;
	nvm_if #(.AW(rst_seq_pkg::NVM_AW), .DW(rst_seq_pkg::NVM_DW)) nvm ();
	nvm_store #(.AW(rst_seq_pkg::NVM_AW), .DW(rst_seq_pkg::NVM_DW)) u_nvm (
		.sys_clk_i(sys_clk_i),
		.bus(nvm.mem)
	);
	assign nvm.rd_en = (state == LOAD) && !rd_pend;
	assign nvm.rd_addr = addr;
	always_comb begin
		next_state = state;
		next_tcnt = tcnt;
		next_limit = limit;
		next_addr = addr;
		next_rd_pend = 1'b0;
		next_busy = busy;
		next_blank = blank;
		next_acc = 1'b0;
		next_dflt = 1'b0;
		next_cv_set = cv_set;
		next_csum = csum;
		unique case (state)
			IDLE: begin
				next_acc = cmd_valid_i; // see (RULE_10)
				if (!filt) begin
					next_state = HELD;
					next_busy = 1'b1; // see (RULE_10)
					next_blank = 1'b1; // see (RULE_05)
					// Awake start needs the longer blanking sequence
					next_limit = awake_i ? 32'(AWAKE_CYC) : 32'(SLEEP_CYC);
					next_tcnt = 32'd0;
				end
			end
			HELD: begin
				if (filt) begin
					next_state = LOAD;
					next_addr = 3'd0;
					next_tcnt = 32'(FILT_CYC);
					next_csum = rst_seq_pkg::CFG_DEFAULT;
				end
			end
			LOAD: begin // see (RULE_04)
				next_tcnt = tcnt + 32'd1;
				next_rd_pend = !rd_pend;
				if (rd_pend) begin
					next_csum = csum + nvm.rd_data;
					if (addr == 3'(rst_seq_pkg::CV_WORD_IDX)) begin
						next_cv_set = nvm.rd_data;
					end
					next_addr = addr + 3'd1;
					if (addr == 3'(rst_seq_pkg::NVM_WORDS - 1)) begin
						next_state = WAIT;
					end
				end
			end
			WAIT: begin
				next_tcnt = tcnt + 32'd1;
				// A fresh valid pulse restarts; the limit picked at first detection is kept
				if (!filt) begin
					next_state = HELD;
				end else if (tcnt >= limit - 32'd1) begin // see (RULE_07)
					next_state = IDLE;
					next_busy = 1'b0;
					next_blank = 1'b0;
					next_dflt = 1'b1; // see (RULE_06)
				end
			end
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= IDLE;
			tcnt <= 32'd0;
			limit <= 32'd0;
			addr <= 3'd0;
			rd_pend <= 1'b0;
			busy <= 1'b0;
			blank <= 1'b0;
			acc <= 1'b0;
			dflt <= 1'b0;
			cv_set <= rst_seq_pkg::CFG_DEFAULT;
			csum <= rst_seq_pkg::CFG_DEFAULT;
		end else begin
			state <= next_state;
			tcnt <= next_tcnt;
			limit <= next_limit;
			addr <= next_addr;
			rd_pend <= next_rd_pend;
			busy <= next_busy;
			blank <= next_blank;
			acc <= next_acc;
			dflt <= next_dflt;
			cv_set <= next_cv_set;
			csum <= next_csum;
		end
	end
	assign busy_o = busy;
	assign blank_o = blank;
	assign cmd_accept_o = acc;
	assign defaults_load_o = dflt;
	assign common_voltage_setting_o = cv_set;
	assign id_checksum_o = csum;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	short_reject_a: assert property ( // see (RULE_02)
		$fell(sync2) && state == IDLE ##1 sync2 [*8] |-> state == IDLE)
		else $error("short low pulse started reset");
	enter_held_a: assert property ( // see (RULE_02)
		state == IDLE && !filt |=> state == HELD && busy)
		else $error("reset not started");
	restart_held_a: assert property ( // see (RULE_02)
		state == WAIT && !filt |=> state == HELD && busy)
		else $error("new pulse did not restart reset");
	spike_hold_a: assert property ( // see (RULE_03)
		state == HELD && $rose(sync2) ##1 !sync2 |-> state == HELD)
		else $error("spike ended reset");
	load_len_a: assert property ( // see (RULE_04)
		$rose(state == LOAD) |-> ##16 state == WAIT)
		else $error("reload length wrong");
	cv_capture_a: assert property ( // see (RULE_04)
		state == LOAD && rd_pend && addr == 3'(rst_seq_pkg::CV_WORD_IDX)
		|=> cv_set == $past(nvm.rd_data))
		else $error("common voltage not reloaded");
	load_before_a: assert property ( // see (RULE_04)
		$fell(busy) |-> $past(state) == WAIT)
		else $error("reset finished without reload");
	busy_blank_a: assert property ( // see (RULE_05)
		busy |-> blank)
		else $error("panel not blank while busy");
	awake_limit_a: assert property ( // see (RULE_05)
		state == IDLE && !filt && awake_i |=> limit == 32'(AWAKE_CYC))
		else $error("awake start lost long blanking");
	sleep_limit_a: assert property ( // see (RULE_07)
		state == IDLE && !filt && !awake_i |=> limit == 32'(SLEEP_CYC))
		else $error("sleep start got wrong limit");
	dflt_pulse_a: assert property ( // see (RULE_06)
		$fell(busy) |-> dflt && !blank)
		else $error("defaults not restored");
	cv_hold_a: assert property ( // see (RULE_06)
		state != LOAD |=> $stable(cv_set))
		else $error("common voltage changed outside reload");
	done_bound_a: assert property ( // see (RULE_07)
		state == WAIT |-> tcnt < limit)
		else $error("completion overran");
	no_accept_a: assert property ( // see (RULE_10)
		busy |=> !acc)
		else $error("command accepted while busy");
	idle_accept_a: assert property ( // see (RULE_10)
		state == IDLE && cmd_valid_i |=> acc)
		else $error("command dropped while idle");
	reset_seen_c: cover property ($rose(busy));
	reset_done_c: cover property ($fell(busy));
	spike_c: cover property (state == HELD && $rose(sync2));
	awake_c: cover property (state == IDLE && !filt && awake_i);
	restart_c: cover property (state == WAIT && !filt);
endmodule : display_hw_reset_sequencer

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
module host_model #(
	parameter int WAIT_CYC = 300
) (
	input wire logic sys_clk_i,
	output logic reset_line_n_o,
	output logic cmd_valid_o
);
	int since = 0;
	int wait_miss = 0;
	initial begin
		reset_line_n_o = 1'b1;
		cmd_valid_o = 1'b0;
	end
	always @(posedge sys_clk_i) since <= reset_line_n_o ? since + 1 : 0;
	task automatic drive_pin(input logic v, input int n);
		@(posedge sys_clk_i);
		reset_line_n_o <= v;
		repeat (n - 1) @(posedge sys_clk_i);
	endtask : drive_pin
	// Early commands are only sent to probe refusal while busy
	task automatic send_cmd(input logic early);
		for (int k = 0; k < 999 && !early && since < WAIT_CYC; k++) @(posedge sys_clk_i);
		if (!early && since < WAIT_CYC) wait_miss++;
		@(posedge sys_clk_i);
		cmd_valid_o <= 1'b1;
		@(posedge sys_clk_i);
		cmd_valid_o <= 1'b0;
	endtask : send_cmd
endmodule : host_model

// ---- dv/display_hw_reset_sequencer_tb.sv ----
`timescale 1ns/1ps
module display_hw_reset_sequencer_tb;
	// ----------------------------------------
	// Shortened counts keep the run brief
	// ----------------------------------------
	localparam int SLP = 100;
	localparam int AWK = 300;
	typedef struct {int low; logic awake; logic hit;} row_t;
	row_t rows [5] = '{'{1, 1'b0, 1'b0}, '{2, 1'b0, 1'b0}, '{3, 1'b1, 1'b0},
		'{10, 1'b0, 1'b1}, '{10, 1'b1, 1'b1}};
	logic sys_clk_i, nrst_i, awake_i, pin_n, cmd_v, busy, blank, acc, load;
	logic seen = 1'b0;
	logic acc_seen = 1'b0;
	logic [7:0] vcs, sum, loads;
	int fail_count = 0;
	int samples_checked = 0;
	host_model #(.WAIT_CYC(AWK)) i_host (.sys_clk_i(sys_clk_i), .reset_line_n_o(pin_n),
		.cmd_valid_o(cmd_v));
	display_hw_reset_sequencer #(.FILT_CYC(4), .SLEEP_CYC(SLP), .AWAKE_CYC(AWK)) i_dut (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reset_line_n_i(pin_n), .awake_i(awake_i),
		.cmd_valid_i(cmd_v), .busy_o(busy), .blank_o(blank), .cmd_accept_o(acc),
		.defaults_load_o(load), .common_voltage_setting_o(vcs), .id_checksum_o(sum));
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		if (busy) seen <= 1'b1;
		if (acc) acc_seen <= 1'b1;
		if (load) loads <= loads + 8'h01;
	end
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic try_cmd(input logic early, input logic exp);
		@(negedge sys_clk_i);
		acc_seen = 1'b0;
		i_host.send_cmd(early);
		repeat (2) @(posedge sys_clk_i);
		#1 chk_byte({7'h00, acc_seen}, {7'h00, exp});
	endtask : try_cmd
	task automatic run_reset(input int low, input logic awake, input logic hit, input int spike);
		int lim, t;
		lim = awake ? AWK : SLP;
		awake_i <= awake;
		@(negedge sys_clk_i);
		seen = 1'b0;
		loads = 8'h00;
		i_host.drive_pin(1'b0, low);
		if (spike > 0) begin
			i_host.drive_pin(1'b1, spike);
			i_host.drive_pin(1'b0, low);
		end
		i_host.drive_pin(1'b1, 1);
		#1 chk_byte({7'h00, seen}, {7'h00, hit});
		chk_byte({7'h00, blank}, {7'h00, hit});
		if (hit) begin
			try_cmd(1'b1, 1'b0);
			for (t = 4; t < lim + 40 && load !== 1'b1; t++) #5;
			if (load !== 1'b1) begin
				fail_count++;
				stop_test();
			end
			chk_byte({7'h00, t >= lim - 8 && t <= lim + 12}, 8'h01);
			#5 chk_byte({6'h00, busy, blank}, 8'h00);
			chk_byte(vcs, 8'h38);
			chk_byte(sum, 8'h04);
			chk_byte(loads, 8'h01);
			try_cmd(1'b0, 1'b1);
		end else begin
			repeat (20) @(posedge sys_clk_i);
			#1 chk_byte({7'h00, seen}, 8'h00);
		end
	endtask : run_reset
	initial begin
		nrst_i = 1'b0;
		awake_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		#1 chk_byte({5'h00, busy, blank, load}, 8'h00);
		foreach (rows[i]) run_reset(rows[i].low, rows[i].awake, rows[i].hit, 0);
		run_reset(10, 1'b0, 1'b1, 2);
		run_reset(10, 1'b0, 1'b1, 1);
		run_reset(10, 1'b0, 1'b1, 30);
		// Block reset lands while a pin reset is held
		i_host.drive_pin(1'b0, 10);
		nrst_i <= 1'b0;
		#1 chk_byte({6'h00, busy, blank}, 8'h00);
		@(posedge sys_clk_i);
		nrst_i <= 1'b1;
		i_host.drive_pin(1'b1, 1);
		run_reset(10, 1'b1, 1'b1, 0);
		chk_byte(8'(i_host.wait_miss), 8'h00);
		stop_test();
	end
endmodule : display_hw_reset_sequencer_tb
